// [pkg/mdsw_pkg.sv]
// Constants and types shared by the display select and link watchdog block
package mdsw_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [15:0] SEL_ADDR = 16'h0043;
  localparam logic [15:0] DISP_ONE_ADDR = 16'h0038;
  localparam logic [15:0] DISP_TWO_ADDR = 16'h0039;
  localparam logic [15:0] SEL_RESET = 16'h0000;
  localparam logic [15:0] ONE_REG = 16'h0001;

  // ************************************************************
  // Function and exception codes
  // ************************************************************
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
  localparam logic [7:0] READ_BYTES = 8'h02;

  // ************************************************************
  // Source codes
  // ************************************************************
  localparam logic [3:0] SRC_NONE = 4'h0;
  localparam logic [3:0] SRC_RET_TEMP = 4'h1;
  localparam logic [3:0] SRC_COND = 4'h2;
  localparam logic [3:0] SRC_PRESS = 4'h3;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int MONITOR_SEC = 180;
  localparam int CLK_PERIOD_NS = 5;
  localparam int NS_PER_SEC = 1000000000;
  localparam int SEC_CYCLES = NS_PER_SEC / CLK_PERIOD_NS;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    RSP_ECHO = 2'b00,
    RSP_READ = 2'b01,
    RSP_EXC = 2'b10
  } mdsw_fmt_t;

  typedef struct packed {
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [15:0] data;
  } mdsw_req_t;

  typedef struct packed {
    mdsw_fmt_t fmt;
    logic [7:0] devAddr;
    logic [7:0] func;
    logic [7:0] byteCount;
    logic [15:0] wordOne;
    logic [15:0] wordTwo;
  } mdsw_rsp_t;

  typedef struct packed {
    logic [15:0] retTemp;
    logic [15:0] conductivity;
    logic [15:0] pressure;
  } mdsw_meas_t;

endpackage

// [core/mdsw_wdog.sv]
// Link watchdog counting whole seconds between host messages
`timescale 1ns/1ps
module mdsw_wdog #(
  parameter int SEC_CYCLES = mdsw_pkg::SEC_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic enable,
  input wire logic kick,
  input wire logic [15:0] limitSec,
  // Status
  output logic alarm,
  output logic alarmRise
);

  typedef struct packed {
    logic [31:0] tick;
    logic [15:0] secs;
    logic alarm;
    logic rise;
  } mdsw_wd_t;

  mdsw_wd_t wd_q;
  mdsw_wd_t wd_d;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    wd_d = wd_q;
    wd_d.rise = 1'b0;
    if (!enable) begin
      wd_d.tick = '0;
      wd_d.secs = '0;
      wd_d.alarm = 1'b0;
    end else if (kick) begin
      wd_d.tick = '0;
      wd_d.secs = '0;
      wd_d.alarm = 1'b0;
    end else if (wd_q.tick == 32'(SEC_CYCLES - 1)) begin
      wd_d.tick = '0;
      if (wd_q.secs != limitSec) begin
        wd_d.secs = wd_q.secs + 16'h0001;
      end
      if (limitSec != 16'h0000 && wd_q.secs + 16'h0001 >= limitSec) begin
        wd_d.alarm = 1'b1;
        wd_d.rise = !wd_q.alarm;
      end
    end else begin
      wd_d.tick = wd_q.tick + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_q <= '0;
    end else begin
      wd_q <= wd_d;
    end
  end

  assign alarm = wd_q.alarm;
  assign alarmRise = wd_q.rise;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking wdcb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_idle_no_alarm: assert property (!enable |=> !alarm && wd_q.secs == 16'h0000)
    else $error("watchdog active while disabled");
  a_kick_clears: assert property (enable && kick |=> !alarm && wd_q.tick == 32'h0)
    else $error("message did not clear watchdog");
  a_alarm_at_limit: assert property ($rose(alarm) |-> wd_q.secs == limitSec)
    else $error("alarm raised before monitoring time");
  a_rise_pulse: assert property (alarmRise |-> alarm ##1 !alarmRise)
    else $error("alarm rise not a single pulse");

endmodule

// [core/mdsw_core.sv]
// Modbus display select registers, serial mode and link watchdog
`timescale 1ns/1ps
module mdsw_core #(
  parameter int SEC_CYCLES = mdsw_pkg::SEC_CYCLES,
  parameter logic [15:0] MONITOR_SEC = 16'(mdsw_pkg::MONITOR_SEC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Decoded request from the framing layer
  input wire logic reqValid,
  input wire mdsw_pkg::mdsw_req_t req,
  input wire logic otherMsg,
  input wire logic [7:0] devAddr,
  // Answer to the framing layer
  output logic rspValid,
  output mdsw_pkg::mdsw_rsp_t rsp,
  // Measured quantities
  input wire mdsw_pkg::mdsw_meas_t meas,
  // Operation control
  input wire logic modeReq,
  input wire logic localModeReq,
  input wire logic startCmd,
  input wire logic stopCmd,
  input wire logic wdEnable,
  input wire logic stopOnAlarm,
  // Status
  output logic serialMode,
  output logic running,
  output logic linkTimeoutAlarm,
  output logic [15:0] displayOne,
  output logic [15:0] displayTwo,
  output logic [15:0] selectValue
);

  typedef struct packed {
    logic [15:0] sel;
    logic [15:0] dispOne;
    logic [15:0] dispTwo;
    logic serial;
    logic modeReqPrev;
    logic run;
    logic rspValid;
    mdsw_pkg::mdsw_rsp_t rsp;
  } mdsw_state_t;

  mdsw_state_t st_q;
  mdsw_state_t st_d;
  logic wdAlarm;
  logic wdRise;

  // ************************************************************
  // Source decode
  // ************************************************************
  function automatic logic [15:0] pickSource(input logic [3:0] code,
                                             input mdsw_pkg::mdsw_meas_t m);
    logic [15:0] val;
    val = 16'h0000;
    unique case (code)
      mdsw_pkg::SRC_RET_TEMP: val = m.retTemp;
      mdsw_pkg::SRC_COND: val = m.conductivity;
      mdsw_pkg::SRC_PRESS: val = m.pressure;
      default: val = 16'h0000;
    endcase
    return val;
  endfunction

  // ************************************************************
  // Watchdog
  // ************************************************************
  mdsw_wdog #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_wdog (
    .clk(clk),
    .sys_rst(sys_rst),
    .enable(wdEnable && st_q.serial),
    .kick(reqValid || otherMsg),
    .limitSec(MONITOR_SEC),
    .alarm(wdAlarm),
    .alarmRise(wdRise)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_d = st_q;
    st_d.rspValid = 1'b0;
    st_d.dispOne = pickSource(st_q.sel[3:0], meas);
    st_d.dispTwo = pickSource(st_q.sel[7:4], meas);
    st_d.modeReqPrev = modeReq;
    if (modeReq && !st_q.modeReqPrev) begin
      st_d.serial = 1'b1;
    end else if (localModeReq) begin
      st_d.serial = 1'b0;
    end
    if (wdRise && stopOnAlarm) begin
      st_d.run = 1'b0;
    end else if (stopCmd) begin
      st_d.run = 1'b0;
    end else if (startCmd) begin
      st_d.run = 1'b1;
    end
    if (reqValid) begin
      st_d.rspValid = 1'b1;
      st_d.rsp.devAddr = devAddr;
      st_d.rsp.func = req.func;
      st_d.rsp.fmt = mdsw_pkg::RSP_ECHO;
      st_d.rsp.byteCount = 8'h00;
      st_d.rsp.wordOne = req.addr;
      st_d.rsp.wordTwo = req.qty;
      if (req.func == mdsw_pkg::FC_WRITE_MULTI) begin
        if (req.addr == mdsw_pkg::SEL_ADDR && req.qty == mdsw_pkg::ONE_REG) begin
          st_d.sel = req.data;
          st_d.rsp.wordTwo = req.qty;
        end else begin
          st_d.rsp.fmt = mdsw_pkg::RSP_EXC;
          st_d.rsp.func = req.func | mdsw_pkg::EXC_FLAG;
          st_d.rsp.byteCount = mdsw_pkg::EXC_BAD_ADDR;
        end
      end else if (req.func == mdsw_pkg::FC_WRITE_SINGLE) begin
        if (req.addr == mdsw_pkg::SEL_ADDR) begin
          st_d.sel = req.data;
          st_d.rsp.wordTwo = req.data;
        end else begin
          st_d.rsp.fmt = mdsw_pkg::RSP_EXC;
          st_d.rsp.func = req.func | mdsw_pkg::EXC_FLAG;
          st_d.rsp.byteCount = mdsw_pkg::EXC_BAD_ADDR;
        end
      end else if (req.func == mdsw_pkg::FC_READ_INPUT) begin
        if (req.qty == mdsw_pkg::ONE_REG && req.addr == mdsw_pkg::DISP_ONE_ADDR) begin
          st_d.rsp.fmt = mdsw_pkg::RSP_READ;
          st_d.rsp.byteCount = mdsw_pkg::READ_BYTES;
          st_d.rsp.wordOne = st_q.dispOne;
          st_d.rsp.wordTwo = 16'h0000;
        end else if (req.qty == mdsw_pkg::ONE_REG && req.addr == mdsw_pkg::DISP_TWO_ADDR) begin
          st_d.rsp.fmt = mdsw_pkg::RSP_READ;
          st_d.rsp.byteCount = mdsw_pkg::READ_BYTES;
          st_d.rsp.wordOne = st_q.dispTwo;
          st_d.rsp.wordTwo = 16'h0000;
        end else begin
          st_d.rsp.fmt = mdsw_pkg::RSP_EXC;
          st_d.rsp.func = req.func | mdsw_pkg::EXC_FLAG;
          st_d.rsp.byteCount = mdsw_pkg::EXC_BAD_ADDR;
        end
      end else begin
        st_d.rsp.fmt = mdsw_pkg::RSP_EXC;
        st_d.rsp.func = req.func | mdsw_pkg::EXC_FLAG;
        st_d.rsp.byteCount = mdsw_pkg::EXC_BAD_FUNC;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.sel <= mdsw_pkg::SEL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rspValid = st_q.rspValid;
  assign rsp = st_q.rsp;
  assign serialMode = st_q.serial;
  assign running = st_q.run;
  assign linkTimeoutAlarm = wdAlarm;
  assign displayOne = st_q.dispOne;
  assign displayTwo = st_q.dispTwo;
  assign selectValue = st_q.sel;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_sel_write_echo: assert property (reqValid && req.func == 8'h10 && req.addr == 16'h0043
      && req.qty == 16'h0001 |=> st_q.sel == $past(req.data) && rspValid
      && rsp.func == 8'h10 && rsp.wordOne == 16'h0043 && rsp.wordTwo == 16'h0001)
    else $error("multi write not stored or echoed");
  a_single_write: assert property (reqValid && req.func == 8'h06 && req.addr == 16'h0043
      |=> st_q.sel == $past(req.data))
    else $error("single write not stored");
  a_read_one: assert property (reqValid && req.func == 8'h04 && req.addr == 16'h0038
      && req.qty == 16'h0001 |=> rspValid && rsp.byteCount == 8'h02
      && rsp.wordOne == $past(st_q.dispOne))
    else $error("display one read answer wrong");
  a_disp_one_src: assert property (st_q.sel[3:0] == 4'h1 |=> displayOne == $past(meas.retTemp))
    else $error("display one source wrong");
  a_disp_two_src: assert property (st_q.sel[7:4] == 4'h3 |=> displayTwo == $past(meas.pressure))
    else $error("display two source wrong");
  a_none_zero: assert property (st_q.sel[3:0] == 4'h0 |=> displayOne == 16'h0000)
    else $error("none source not zero");
  a_mode_enter: assert property (modeReq && !st_q.modeReqPrev |=> serialMode ##1
      (serialMode || $past(localModeReq)))
    else $error("serial mode not entered or not held");
  a_alarm_keeps_run: assert property (wdRise && !stopOnAlarm && !startCmd && !stopCmd
      |=> running == $past(running))
    else $error("alarm changed run state");
  a_stay_stopped: assert property (!running && !startCmd |=> !running)
    else $error("unit restarted without start command");
  a_alarm_stops: assert property (wdRise && stopOnAlarm |=> !running)
    else $error("stop on alarm ignored");

endmodule

// [dv/mdsw_host.sv]
// Host master model issuing decoded requests to the block
`timescale 1ns/1ps
module mdsw_host (
  // Clock
  clk,
  // Requests
  reqValid,
  req,
  otherMsg,
  // Answers
  rspValid,
  rsp
);
  input wire logic clk;
  output logic reqValid;
  output mdsw_pkg::mdsw_req_t req;
  output logic otherMsg;
  input wire logic rspValid;
  input wire mdsw_pkg::mdsw_rsp_t rsp;
  mdsw_pkg::mdsw_rsp_t got;
  logic gotValid;
  initial begin
    reqValid = 1'b0;
    req = '0;
    otherMsg = 1'b0;
  end
  // ************************************************************
  // One request, answer taken one cycle on
  // ************************************************************
  task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    reqValid = 1'b1;
    req = '{func: f, addr: a, qty: 16'h0001, data: d};
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    req = ~req;
    gotValid = rspValid;
    got = rsp;
  endtask
  // Message with no register answer
  task automatic poke();
    @(posedge clk);
    #1;
    otherMsg = 1'b1;
    @(posedge clk);
    #1;
    otherMsg = 1'b0;
  endtask
endmodule

// [dv/testbench.sv]
// Self-checking bench for the display select and link watchdog block
`timescale 1ns/1ps
module testbench;
  localparam int SECC = 4;
  logic clk, sysRst, reqValid, otherMsg, rspValid, modeReq, localModeReq;
  logic startCmd, stopCmd, wdEnable, stopOnAlarm, serialMode, running, linkTimeoutAlarm;
  logic [7:0] devAddr;
  logic [15:0] displayOne, displayTwo, selectValue, sel;
  mdsw_pkg::mdsw_req_t req;
  mdsw_pkg::mdsw_rsp_t rsp;
  mdsw_pkg::mdsw_meas_t meas;
  int n_errors = 0;
  int checks = 0;
  mdsw_core #(.SEC_CYCLES(SECC), .MONITOR_SEC(16'h0003)) uut (.clk(clk), .sys_rst(sysRst),
    .reqValid(reqValid), .req(req), .otherMsg(otherMsg), .devAddr(devAddr),
    .rspValid(rspValid), .rsp(rsp), .meas(meas), .modeReq(modeReq),
    .localModeReq(localModeReq), .startCmd(startCmd), .stopCmd(stopCmd),
    .wdEnable(wdEnable), .stopOnAlarm(stopOnAlarm), .serialMode(serialMode),
    .running(running), .linkTimeoutAlarm(linkTimeoutAlarm), .displayOne(displayOne),
    .displayTwo(displayTwo), .selectValue(selectValue));
  mdsw_host host (.clk(clk), .reqValid(reqValid), .req(req), .otherMsg(otherMsg),
    .rspValid(rspValid), .rsp(rsp));
  // ************************************************************
  // Model and checking
  // ************************************************************
  function automatic logic [15:0] pick(input int nib);
    case (nib)
      1: return meas.retTemp;
      2: return meas.conductivity;
      3: return meas.pressure;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    n_errors++;
    finish_test();
  end
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    sysRst = 1'b1;
    devAddr = 8'h01;
    meas = '0;
    {modeReq, localModeReq, startCmd, stopCmd, wdEnable, stopOnAlarm} = '0;
    void'($urandom(32'h9103));
    repeat (10) @(posedge clk);
    #1;
    sysRst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      meas = {16'($urandom), 16'($urandom), 16'($urandom)};
      sel = {8'h00, 4'(i / 4), 4'(i % 4)};
      host.send((i % 2) ? 8'h10 : 8'h06, 16'h0043, sel);
      check({15'h0, host.gotValid}, 16'h0001);
      check({host.got.devAddr, host.got.func}, {8'h01, (i % 2) ? 8'h10 : 8'h06});
      check(host.got.wordOne, 16'h0043);
      check(host.got.wordTwo, (i % 2) ? 16'h0001 : sel);
      check({14'h0, host.got.fmt}, 16'h0000);
      wait_cyc(2);
      check(displayOne, pick(i % 4));
      check(displayTwo, pick(i / 4));
      check(selectValue, sel);
      for (int r = 0; r < 2; r++) begin
        host.send(8'h04, 16'h0038 + 16'(r), 16'h0000);
        check({host.got.func, host.got.byteCount}, 16'h0402);
        check({14'h0, host.got.fmt}, 16'h0001);
        check(host.got.wordOne, pick(r ? i / 4 : i % 4));
      end
    end
    $display("Test select done");
    host.send(8'h04, 16'h0043, 16'h0000);
    check({host.got.func, host.got.byteCount}, 16'h8402);
    host.send(8'h03, 16'h0038, 16'h0000);
    check({host.got.func, host.got.byteCount}, 16'h8301);
    check({14'h0, host.got.fmt}, 16'h0002);
    host.send(8'h10, 16'h0038, 16'h0005);
    check({host.got.func, host.got.byteCount}, 16'h9002);
    check(selectValue, sel);
    $display("Test errors done");
    startCmd = 1'b1;
    wait_cyc(1);
    startCmd = 1'b0;
    wdEnable = 1'b1;
    wait_cyc(30);
    check({15'h0, linkTimeoutAlarm}, 16'h0000);
    modeReq = 1'b1;
    wait_cyc(3);
    modeReq = 1'b0;
    wait_cyc(2);
    check({15'h0, serialMode}, 16'h0001);
    for (int k = 0; k < 6; k++) begin
      wait_cyc(5);
      host.poke();
      check({15'h0, linkTimeoutAlarm}, 16'h0000);
    end
    for (int s = 0; s < 2; s++) begin
      stopOnAlarm = s[0];
      wait_cyc(20);
      check({15'h0, linkTimeoutAlarm}, 16'h0001);
      check({15'h0, running}, s ? 16'h0000 : 16'h0001);
      host.poke();
      wait_cyc(1);
      check({15'h0, linkTimeoutAlarm}, 16'h0000);
      check({15'h0, running}, s ? 16'h0000 : 16'h0001);
    end
    startCmd = 1'b1;
    wait_cyc(1);
    startCmd = 1'b0;
    wait_cyc(1);
    check({15'h0, running}, 16'h0001);
    wdEnable = 1'b0;
    wait_cyc(25);
    check({15'h0, linkTimeoutAlarm}, 16'h0000);
    stopCmd = 1'b1;
    wait_cyc(1);
    stopCmd = 1'b0;
    wait_cyc(1);
    check({15'h0, running}, 16'h0000);
    localModeReq = 1'b1;
    wait_cyc(1);
    localModeReq = 1'b0;
    wait_cyc(1);
    check({15'h0, serialMode}, 16'h0000);
    $display("Test watchdog done");
    finish_test();
  end
endmodule
